// >>> logic/wsbc_top.sv
// Purpose: Wait-state bus controller between a 32-bit processor and its peripherals
// Assumes: sys_clk is the double-rate clock; all inputs synchronous to it
// Notes: Strobes, ready and transceiver enable are registered outputs
// What this block does
// RULE1: Follow every bus cycle and hold ready_n high while wait states are needed.
// RULE2: A slow-memory read gets exactly 14 wait states before ready is returned.
// RULE3: Decode I/O read, I/O write and interrupt-acknowledge strobes from the status inputs.
// RULE4: Drive the active-low transceiver enable; direction comes from the write-or-read line.
// RULE5: Assert peripheral strobes before the first bus clock period of a cycle ends.
// RULE6: All logic runs on the double-rate clock so waits count in about 15 ns steps.
// RULE7: Cycle type comes from memory-or-io, write-or-read, data-or-control; address top bit picks slow memory.
// RULE8: The processor starts each cycle by driving ads_n low and tracking starts there.
// RULE9: An asserted next_addr_req_n disables the controller and no wait states are inserted; the code still tracks the cycle and decodes strobes.
// RULE10: On next_addr_req_n the processor presents the next address early.
// RULE11: While dyn_mem_ready_n is high ready_n stays high; when low the processor may proceed.
// RULE12: A toggle flip-flop on the double-rate clock makes a half-rate phase clock.
// RULE13: Reset puts every register in its idle state.
// RULE14: A loadable 4-bit counter counts waits; when done its delay output drops and ready is released.
// RULE15: From idle the tracker goes active when ads_n is low while the phase clock is high.
// RULE16: The counter is preloaded at cycle start from cycle type and address top bit.
`timescale 1ns/1ps
module wsbc_top #(
  parameter logic [3:0] SLOW_WAITS = wsbc_pkg::SLOW_MEM_WAITS
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ads_n,
  input wire logic mem_io,
  input wire logic wr_rd,
  input wire logic data_ctl,
  input wire logic addr_top_bit,
  input wire logic next_addr_req_n,
  input wire logic dyn_mem_ready_n,
  output logic ready_n,
  output logic io_read_strobe,
  output logic io_write_strobe,
  output logic irq_ack_strobe,
  output logic xcvr_enable_n,
  output logic phase_clk,
  output logic cycle_active_n
);

  wsbc_pkg::wsbc_state_t state_q;
  logic [3:0] wait_q;
  logic delay_q;
  logic [2:0] ctype;
  logic start;
  logic done;
  logic bypass;

  // Preload count from cycle type and memory region
  function automatic logic [3:0] wsbc_waits(input logic [2:0] t, input logic top);
    if (t == wsbc_pkg::TYPE_MEM_RD && top)
      wsbc_waits = SLOW_WAITS;
    else if (t == wsbc_pkg::TYPE_IO_RD || t == wsbc_pkg::TYPE_IO_WR)
      wsbc_waits = wsbc_pkg::IO_WAITS;
    else if (t == wsbc_pkg::TYPE_IRQ_ACK_STROBE)
      wsbc_waits = wsbc_pkg::IRQ_ACK_STROBE_WAITS;
    else
      wsbc_waits = wsbc_pkg::DEFAULT_WAITS;
  endfunction

  // Cycle decode and handshake terms
  assign ctype = {mem_io, wr_rd, data_ctl}; // [RULE7]
  assign bypass = !next_addr_req_n; // Pipelined systems gain nothing from waits [RULE9]
  assign start = (state_q == wsbc_pkg::WSBC_IDLE) && !ads_n && phase_clk; // [RULE8] [RULE15]
  assign done = (state_q == wsbc_pkg::WSBC_ACTIVE) && !ready_n && phase_clk;

  // Half-rate phase clock tracking processor clock [RULE12] [RULE6]
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      phase_clk <= 1'b0; // [RULE13]
    else
      phase_clk <= !phase_clk;
  end

  // Bus tracking state machine
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state_q <= wsbc_pkg::WSBC_IDLE; // [RULE13]
    else
    begin
      case (state_q)
        wsbc_pkg::WSBC_IDLE:
        begin
          if (start)
            state_q <= wsbc_pkg::WSBC_ACTIVE; // [RULE15]
        end
        wsbc_pkg::WSBC_ACTIVE:
        begin
          if (done && ads_n)
            state_q <= wsbc_pkg::WSBC_IDLE;
          else if (done)
            state_q <= wsbc_pkg::WSBC_PIPE;
        end
        wsbc_pkg::WSBC_PIPE:
        begin
          if (phase_clk)
            state_q <= wsbc_pkg::WSBC_ACTIVE;
        end
        default:
          state_q <= wsbc_pkg::WSBC_IDLE;
      endcase
    end
  end

  // Cycle-active output, low from a start in idle until the first done
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      cycle_active_n <= 1'b1;
    else if (start)
      cycle_active_n <= 1'b0; // [RULE15]
    else if (done)
      cycle_active_n <= 1'b1;
  end

  // Loadable 4-bit wait counter; delay_q high while waits remain [RULE14]
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wait_q <= wsbc_pkg::CNT_ZERO;
      delay_q <= 1'b0;
    end
    else if (start)
    begin
      wait_q <= bypass ? wsbc_pkg::CNT_ZERO : wsbc_waits(ctype, addr_top_bit); // [RULE16] [RULE2] [RULE9]
      delay_q <= !bypass && (wsbc_waits(ctype, addr_top_bit) != wsbc_pkg::CNT_ZERO);
    end
    else if (wait_q != wsbc_pkg::CNT_ZERO)
    begin
      wait_q <= wait_q - wsbc_pkg::CNT_ONE; // One step per double-rate period [RULE6]
      delay_q <= (wait_q != wsbc_pkg::CNT_ONE);
    end
    else
      delay_q <= 1'b0;
  end

  // Ready held high through waits and while dynamic memory is busy [RULE1] [RULE11]
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ready_n <= 1'b1;
    else if (state_q == wsbc_pkg::WSBC_ACTIVE && !start && !done)
      ready_n <= delay_q || (wait_q != wsbc_pkg::CNT_ZERO) || dyn_mem_ready_n; // [RULE14]
    else
      ready_n <= 1'b1;
  end

  // Peripheral strobes set the edge after cycle start, inside the first bus period [RULE3] [RULE5]
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      io_read_strobe <= 1'b0;
      io_write_strobe <= 1'b0;
      irq_ack_strobe <= 1'b0;
    end
    else if (start)
    begin
      io_read_strobe <= (ctype == wsbc_pkg::TYPE_IO_RD);
      io_write_strobe <= (ctype == wsbc_pkg::TYPE_IO_WR);
      irq_ack_strobe <= (ctype == wsbc_pkg::TYPE_IRQ_ACK_STROBE);
    end
    else if (done)
    begin
      io_read_strobe <= 1'b0;
      io_write_strobe <= 1'b0;
      irq_ack_strobe <= 1'b0;
    end
  end

  // Transceiver enable; external direction follows wr_rd directly [RULE4]
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      xcvr_enable_n <= 1'b1;
    else if (start && next_addr_req_n)
      xcvr_enable_n <= 1'b0;
    else if (done || state_q == wsbc_pkg::WSBC_IDLE)
      xcvr_enable_n <= 1'b1;
  end

  // Slow read sees the full wait count on ready
  sequence s_slow_start;
    start && next_addr_req_n && ctype == wsbc_pkg::TYPE_MEM_RD && addr_top_bit;
  endsequence
  // Fifteen sampled-high edges, then ready follows dynamic memory alone
  sequence s_slow_hold;
    ready_n [*8] ##1 ready_n [*7];
  endsequence
  chk_slow_read_waits: assert property (@(posedge sys_clk) disable iff (srst) // [RULE2]
    s_slow_start |=> s_slow_hold ##1 (ready_n == $past(dyn_mem_ready_n)))
    else $error("slow read wait count wrong");
  chk_ready_dyn_mem: assert property (@(posedge sys_clk) disable iff (srst) // [RULE11]
    $past(dyn_mem_ready_n) |-> ready_n)
    else $error("ready low while dynamic memory busy");
  chk_bypass_nowait: assert property (@(posedge sys_clk) disable iff (srst) // [RULE9]
    start && !next_addr_req_n |=> wait_q == wsbc_pkg::CNT_ZERO && !delay_q)
    else $error("waits inserted in pipelined mode");
  chk_strobe_timely: assert property (@(posedge sys_clk) disable iff (srst) // [RULE5]
    start && ctype == wsbc_pkg::TYPE_IO_RD |=> io_read_strobe)
    else $error("io read strobe late");
  chk_start_active: assert property (@(posedge sys_clk) disable iff (srst) // [RULE15]
    state_q == wsbc_pkg::WSBC_IDLE && !ads_n && phase_clk |=> !cycle_active_n)
    else $error("tracker did not go active");
  chk_phase_toggle: assert property (@(posedge sys_clk) disable iff (srst) // [RULE12]
    phase_clk |=> !phase_clk)
    else $error("phase clock not toggling");
  chk_xcvr_enable: assert property (@(posedge sys_clk) disable iff (srst) // [RULE4]
    start && next_addr_req_n |=> !xcvr_enable_n)
    else $error("transceiver not enabled");
  chk_ready_idle: assert property (@(posedge sys_clk) disable iff (srst) // [RULE1]
    state_q == wsbc_pkg::WSBC_IDLE |=> ready_n)
    else $error("ready low outside cycle");
  chk_reset_idle: assert property (@(posedge sys_clk) // [RULE13]
    srst |=> state_q == wsbc_pkg::WSBC_IDLE && ready_n && xcvr_enable_n)
    else $error("reset did not idle");

endmodule

// >>> logic/wsbc_pkg.sv
// Purpose: Shared constants for the wait-state bus controller
// Assumes: Controller clock is the double-rate clock (sys_clk)
// Notes: Wait counts are in double-rate clock periods
package wsbc_pkg;
  // Double-rate clock period in ps (66 MHz nominal, about 15 ns)
  localparam int CLK_PERIOD_PS = 15000;
  // Slow memory access time in ns
  localparam int SLOW_MEM_NS = 200;
  // Wait states demanded by a slow-memory read
  localparam logic [3:0] SLOW_MEM_WAITS = 4'h000E;
  // Wait states for an I/O read, I/O write, interrupt acknowledge
  localparam logic [3:0] IO_WAITS = 4'h0004;
  localparam logic [3:0] IRQ_ACK_STROBE_WAITS = 4'h0002;
  // Wait states for any other cycle
  localparam logic [3:0] DEFAULT_WAITS = 4'h0000;
  // Counter terminal value
  localparam logic [3:0] CNT_ZERO = 4'h0000;
  localparam logic [3:0] CNT_ONE = 4'h0001;
  // Cycle types from memory-or-io, write-or-read, data-or-control
  localparam logic [2:0] TYPE_IRQ_ACK_STROBE = 3'h0;
  localparam logic [2:0] TYPE_IO_RD = 3'h2;
  localparam logic [2:0] TYPE_IO_WR = 3'h3;
  localparam logic [2:0] TYPE_MEM_RD = 3'h6;
  typedef enum logic [1:0] {WSBC_IDLE, WSBC_ACTIVE, WSBC_PIPE} wsbc_state_t;
endpackage

// >>> verif/wsbc_cpu_model.sv
// Purpose: Processor side of the bus for the wait-state controller
// Assumes: Called just after a sys_clk rising edge
// Notes: Released status lines invert so stale levels never pass
`timescale 1ns/1ps
module wsbc_cpu_model (
  input wire logic sys_clk,
  input wire logic phase_clk,
  input wire logic ready_n,
  input wire logic [4:0] obs,
  output logic ads_n,
  output logic mem_io,
  output logic wr_rd,
  output logic data_ctl,
  output logic addr_top_bit
);
  // Idle bus at time zero
  initial {ads_n, mem_io, wr_rd, data_ctl, addr_top_bit} = 5'h10;
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  // One bus cycle: n counts edges from start, snap is the view one cycle in
  task automatic run(input logic [3:0] kind, output int n, output logic [4:0] snap);
    n = 0;
    while (phase_clk !== 1'b1) tick();
    ads_n = 1'b0;
    {mem_io, wr_rd, data_ctl, addr_top_bit} = kind; // Address is up with the strobe
    do
    begin
      tick();
      ads_n = 1'b1;
      n++;
      if (n == 2) snap = obs;
    end while (ready_n !== 1'b0 && n < 200);
    // Ready only ends the cycle on a phase-high edge
    while (phase_clk !== 1'b1) tick();
    tick();
    {mem_io, wr_rd, data_ctl, addr_top_bit} = ~kind;
  endtask
endmodule

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the wait-state bus controller
// Assumes: Default slow-memory wait count of 14
// Notes: Expected waits come from a small integer model
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic next_addr_req_n = 1'b1;
  logic dyn_mem_ready_n = 1'b0;
  logic ads_n, mem_io, wr_rd, data_ctl, addr_top_bit, last_ph;
  logic ready_n, io_read_strobe, io_write_strobe, irq_ack_strobe, xcvr_enable_n, phase_clk, cycle_active_n;
  logic [4:0] snap;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 91;
  int n;
  always #2.5 sys_clk = ~sys_clk;
  wsbc_top uut (.sys_clk, .srst, .ads_n, .mem_io, .wr_rd, .data_ctl, .addr_top_bit, .next_addr_req_n,
    .dyn_mem_ready_n, .ready_n, .io_read_strobe, .io_write_strobe, .irq_ack_strobe, .xcvr_enable_n,
    .phase_clk, .cycle_active_n);
  wsbc_cpu_model cpu (.sys_clk, .phase_clk, .ready_n, .ads_n, .mem_io, .wr_rd, .data_ctl, .addr_top_bit,
    .obs({cycle_active_n, xcvr_enable_n, io_read_strobe, io_write_strobe, irq_ack_strobe}));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reference wait count; pipelined cycles bypass the counter
  function automatic int waits(logic [3:0] k, logic na);
    if (!na) return 0;
    case (k[3:1])
      3'h6: return k[0] ? 14 : 0;
      3'h2, 3'h3: return 4;
      3'h0: return 2;
      default: return 0;
    endcase
  endfunction
  // Strobes are only judged on non-pipelined cycles
  task automatic one(input logic [3:0] k, input logic na);
    logic [4:0] e;
    next_addr_req_n = na;
    cpu.run(k, n, snap);
    check(8'(n), 8'(2 + waits(k, na)));
    e = {1'b0, ~na, na && k[3:1] == 3'h2, na && k[3:1] == 3'h3, na && k[3:1] == 3'h0};
    if (!na) snap[2:0] = 3'h0;
    check({3'h0, snap}, {3'h0, e});
  endtask
  // Phase flips every edge once reset has settled; also the hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    last_ph = phase_clk;
    #1;
    if (cycles > 11) check({7'h0, phase_clk}, {7'h0, ~last_ph});
    // Hang guard comes last so nothing runs after the verdict
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    #1;
    check({ready_n, io_read_strobe, io_write_strobe, irq_ack_strobe, xcvr_enable_n, cycle_active_n,
      phase_clk, 1'b0}, 8'h8C);
    srst = 1'b0;
    $display("reset test done");
    for (int k = 0; k < 16; k++) one(4'(k), 1'b1);
    $display("cycle type test done");
    repeat (24) one(4'($random(seed)), 1'($random(seed) % 4 != 0));
    $display("random cycle test done");
    // Slow dynamic memory holds the cycle well past the counter
    next_addr_req_n = 1'b1;
    dyn_mem_ready_n = 1'b1;
    fork
      cpu.run(4'h4, n, snap);
      begin
        repeat (30) @(posedge sys_clk);
        #1 dyn_mem_ready_n = 1'b0;
      end
    join
    check(8'(n >= 28 && n <= 34), 8'h01);
    $display("memory ready test done");
    finish_test();
  end
endmodule
